// [rtl/efs_defines.vh]
// Constants of the emergency halt unit
// Notes on behaviour
// - A high-to-low transition of the filtered halt input stops the running ramp at once.
// - On that transition the halted event flag at bit 10 of the event register is set.
// - The halted event flag stays set until a device reset and nothing else clears it.
// - The halt input is recognised only after three consecutive low samples.
// - The halt input is always active low and no setting changes that.
// - The halt deceleration sits in bits 23:0 of the read-write halt register at 0x4e.
// - The halt current scale sits in bits 31:24 of the same register.
// - The halt register takes one write after reset, only before any ramp start.
// - The halt register always reads back its contents, locked or not.
// - While halted the ramp registers stay readable.
// - A zero deceleration gives a hard stop, a nonzero one a linear ramp to standstill.
// - The deceleration is a raw velocity step per clock, independent of unit settings.
// - A zero scale keeps the last scale in force, a nonzero one is applied while halted.
// - The halt scale feeds the current path exactly like the ordinary scale values.
`ifndef EFS_DEFINES_VH
`define EFS_DEFINES_VH
`define EFS_ADDR_HALT_PARAMS 7'h4e
`define EFS_ADDR_EVENT_FLAG_REGISTER 7'h0e
`define EFS_ADDR_VACTUAL 7'h22
`define EFS_EVT_HALTED_BIT 10
`define EFS_DECEL_MSB 23
`define EFS_SCALE_LSB 24
`define EFS_SCALE_MSB 31
`define EFS_HALT_PARAMS_RESET 32'h00000000
`define EFS_FILTER_TAPS 3
`endif

// [rtl/efs_halt_filter.v]
// Three-sample filter and falling-edge detector for the halt input
`default_nettype none
module efs_halt_filter #(
   parameter TAPS = 3
) (
   input wire mclk,
   input wire rst,
   input wire emergency_halt_n,
   output reg halt_level_reg,
   output wire halt_fall
);
   reg [TAPS-1:0] sample_reg;
   reg prev_reg;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         sample_reg <= {TAPS{1'b1}};
         halt_level_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         sample_reg <= {sample_reg[TAPS-2:0], emergency_halt_n};
         // Low-active only; no polarity option exists
         if (sample_reg == {TAPS{1'b0}}) begin
            halt_level_reg <= 1'b1;
         end else if (sample_reg == {TAPS{1'b1}}) begin
            halt_level_reg <= 1'b0;
         end
         prev_reg <= halt_level_reg;
      end
   end
   assign halt_fall = halt_level_reg & ~prev_reg;
endmodule // efs_halt_filter
`default_nettype wire

// [rtl/efs_emergency_halt.v]
// Emergency halt unit: filter, halt register, ramp stop and current scale override
`include "efs_defines.vh"
`default_nettype none
module efs_emergency_halt #(
   parameter VW = 32
) (
   input wire mclk,
   input wire rst,
   input wire emergency_halt_n,
   input wire [6:0] reg_addr,
   input wire reg_wr,
   input wire [31:0] reg_wdata,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire ramp_start,
   input wire [VW-1:0] v_target,
   input wire [7:0] normal_scale,
   output reg [VW-1:0] v_actual,
   output reg [7:0] scale_out,
   output reg [31:0] event_flag_register,
   output wire halted,
   output wire halt_params_locked
);
   reg [31:0] params_reg;
   reg locked_reg;
   reg started_reg;
   reg halted_event_reg;
   reg [7:0] held_scale_reg;
   reg [VW-1:0] v_next;
   // Next values of the halt register and its lock
   reg [31:0] params_next;
   reg locked_next;
   reg started_next;
   // Next values of the sticky halt state
   reg halted_event_next;
   reg [31:0] event_flag_register_next;
   reg [7:0] held_scale_next;
   reg [7:0] scale_next;
   reg [31:0] rdata_next;
   wire hit_params;
   wire hit_event_flag_register;
   wire hit_vactual;
   wire params_wr_hit;
   wire decel_is_zero;
   wire scale_is_zero;
   wire stop_active;
   wire halt_level;
   wire halt_fall;
   wire [`EFS_DECEL_MSB:0] halt_decel;
   wire [7:0] halt_current_scale;
   wire [VW-1:0] mag;
   wire neg;
   wire [VW-1:0] decel_ext;

   efs_halt_filter #(
      .TAPS(`EFS_FILTER_TAPS)
   ) u_filter (
      .mclk(mclk),
      .rst(rst),
      .emergency_halt_n(emergency_halt_n),
      .halt_level_reg(halt_level),
      .halt_fall(halt_fall)
   );

   assign halt_decel = params_reg[`EFS_DECEL_MSB:0];
   assign halt_current_scale = params_reg[`EFS_SCALE_MSB:`EFS_SCALE_LSB];
   assign halted = halted_event_reg;
   assign halt_params_locked = locked_reg;
   assign neg = v_actual[VW-1];
   assign mag = neg ? (~v_actual + {{(VW-1){1'b0}}, 1'b1}) : v_actual;
   // Decel is taken as raw velocity units per clock; no unit or clock scaling
   assign decel_ext = {{(VW-24){1'b0}}, halt_decel};
   assign decel_is_zero = (halt_decel == {(`EFS_DECEL_MSB+1){1'b0}});
   assign scale_is_zero = (halt_current_scale == 8'h00);
   // The edge pulse joins the level so the stop starts in the cycle it is seen
   assign stop_active = halted_event_reg | halt_fall;

   // Address decode shared by the write qualifier and the read mux
   assign hit_params = (reg_addr == `EFS_ADDR_HALT_PARAMS);
   assign hit_event_flag_register = (reg_addr == `EFS_ADDR_EVENT_FLAG_REGISTER);
   assign hit_vactual = (reg_addr == `EFS_ADDR_VACTUAL);

   // A write racing the first ramp start loses, so it cannot slip past the lock
   assign params_wr_hit = reg_wr && hit_params && !locked_reg
      && !started_reg && !ramp_start;

   // One write after reset, and only before the first ramp start
   always @* begin
      params_next = params_reg;
      locked_next = locked_reg;
      started_next = started_reg;
      if (ramp_start) begin
         started_next = 1'b1;
      end
      if (params_wr_hit) begin
         params_next = reg_wdata;
         locked_next = 1'b1;
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         params_reg <= `EFS_HALT_PARAMS_RESET;
         locked_reg <= 1'b0;
         started_reg <= 1'b0;
      end else begin
         params_reg <= params_next;
         locked_reg <= locked_next;
         started_reg <= started_next;
      end
   end

   // Sticky halted state; no clear path exists besides reset
   // Halt never ends without reset, even if the input returns high
   always @* begin
      halted_event_next = halted_event_reg;
      event_flag_register_next = event_flag_register;
      held_scale_next = held_scale_reg;
      if (halt_fall) begin
         halted_event_next = 1'b1;
         event_flag_register_next[`EFS_EVT_HALTED_BIT] = 1'b1;
      end
      // Last scale before the halt is kept for a zero halt scale
      if (!halted_event_reg) begin
         held_scale_next = scale_out;
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         halted_event_reg <= 1'b0;
         held_scale_reg <= 8'h00;
         event_flag_register <= 32'h00000000;
      end else begin
         halted_event_reg <= halted_event_next;
         held_scale_reg <= held_scale_next;
         event_flag_register <= event_flag_register_next;
      end
   end

   // Ramp: follow target normally; on halt, hard stop or linear decel to zero
   always @* begin
      v_next = v_actual;
      if (stop_active) begin
         if (decel_is_zero) begin
            v_next = {VW{1'b0}};
         end else if (mag <= decel_ext) begin
            // Clamp so the last step never overshoots through zero
            v_next = {VW{1'b0}};
         end else if (neg) begin
            v_next = v_actual + decel_ext;
         end else begin
            v_next = v_actual - decel_ext;
         end
      end else begin
         v_next = v_target;
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         v_actual <= {VW{1'b0}};
      end else begin
         v_actual <= v_next;
      end
   end

   // Same output path as the normal scale, so downstream treats it alike
   always @* begin
      scale_next = normal_scale;
      if (halted_event_reg) begin
         if (scale_is_zero) begin
            scale_next = held_scale_reg;
         end else begin
            scale_next = halt_current_scale;
         end
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         scale_out <= 8'h00;
      end else begin
         scale_out <= scale_next;
      end
   end

   // Reads never depend on lock or halt state
   // Limitation: only the low 32 bits of the velocity are visible on the bus
   always @* begin
      rdata_next = reg_rdata;
      if (reg_rd) begin
         if (hit_params) begin
            rdata_next = params_reg;
         end else if (hit_event_flag_register) begin
            rdata_next = event_flag_register;
         end else if (hit_vactual) begin
            rdata_next = v_actual[31:0];
         end else begin
            rdata_next = 32'h00000000;
         end
      end
   end

   // Read data holds between reads
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= rdata_next;
      end
   end
endmodule // efs_emergency_halt
`default_nettype wire

// [bench/efs_halt_supervisor.sv]
// Board supervision model driving the halt input
`default_nettype none
module efs_halt_supervisor (
   input wire logic mclk,
   output logic emergency_halt_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial emergency_halt_n = 1'b1;
   // Pulled up when released, so idle reads high
   task automatic pull_low(input int n);
      emergency_halt_n <= 1'b0;
      repeat (n) @(posedge mclk);
      emergency_halt_n <= 1'b1;
   endtask
endmodule // efs_halt_supervisor
`default_nettype wire

// [bench/efs_emergency_halt_assertions.sv]
// Assertions for the emergency halt unit
`default_nettype none
module efs_emergency_halt_assertions #(
   parameter int VW = 32
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic emergency_halt_n,
   input wire logic reg_wr,
   input wire logic [VW-1:0] v_actual,
   input wire logic [31:0] event_flag_register,
   input wire logic halted,
   input wire logic halt_params_locked
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_flag_sticky: assert property (event_flag_register[10] |=> event_flag_register[10])
      else $error("flag lost");
   a_flag_halt: assert property (halted == event_flag_register[10])
      else $error("flag apart");
   a_three_low: assert property ((!emergency_halt_n)[*3] |-> ##[0:4] halted)
      else $error("no halt");
   a_no_glitch: assert property (emergency_halt_n[*7] ##0 !halted |=> !halted)
      else $error("stray halt");
   a_zero_holds: assert property (halted && v_actual == '0 |=> v_actual == '0 && halted)
      else $error("moved");
   a_decel_moves: assert property (halted && $past(halted) && v_actual != '0 |-> $changed(v_actual))
      else $error("stuck");
   a_lock_sticky: assert property (halt_params_locked |=> halt_params_locked)
      else $error("unlocked");
   a_lock_cause: assert property ($rose(halt_params_locked) |-> $past(reg_wr))
      else $error("lock cause");
   c_halt: cover property ($rose(halted));
   c_lock: cover property ($rose(halt_params_locked));
   c_ramp: cover property (halted && v_actual != '0);
endmodule // efs_emergency_halt_assertions
bind efs_emergency_halt efs_emergency_halt_assertions #(.VW(VW)) i_chk (.mclk, .rst,
   .emergency_halt_n, .reg_wr, .v_actual, .event_flag_register, .halted, .halt_params_locked);
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the emergency halt unit
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ramp_start = 1'b0;
   logic emergency_halt_n, halted, halt_params_locked;
   logic [6:0] reg_addr = 7'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, v_target = 32'h0, v_actual, event_flag_register, p;
   logic [7:0] normal_scale = 8'h00, scale_out;
   int error_cnt = 0, n_compared = 0, v, d, k;
   always #20 mclk = ~mclk;
   efs_emergency_halt i_dut (.mclk, .rst, .emergency_halt_n, .reg_addr, .reg_wr, .reg_wdata,
      .reg_rd, .reg_rdata, .ramp_start, .v_target, .normal_scale, .v_actual, .scale_out,
      .event_flag_register, .halted, .halt_params_locked);
   efs_halt_supervisor i_sup (.mclk, .emergency_halt_n);
   task automatic tally_and_finish();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Read data is registered, so it is looked at on the following falling edge
   task automatic acc(input logic [6:0] a, input logic w, input logic [31:0] dat, input logic [31:0] e);
      reg_addr <= a;
      reg_wr <= w;
      reg_rd <= !w;
      reg_wdata <= dat;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge mclk);
      if (!w) chk(reg_rdata, e);
      @(posedge mclk);
   endtask
   task automatic halt_wait();
      for (k = 0; halted !== 1'b1; k++) begin
         @(negedge mclk);
         if (k > 12) begin
            error_cnt++;
            tally_and_finish();
         end
      end
   endtask
   initial begin
      p = $urandom(23);
      p = {8'h01 + 8'($urandom % 255), 24'($urandom % 200 + 200)};
      d = p[23:0];
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      acc(7'h4e, 0, 0, 32'h0);
      acc(7'h4e, 1, p, 0);
      chk(halt_params_locked, 32'h1);
      acc(7'h4e, 1, ~p, 0);
      acc(7'h4e, 0, 0, p);
      acc(7'h33, 0, 0, 32'h0);
      v_target <= 32'd6000 + $urandom % 999;
      normal_scale <= 8'($urandom);
      ramp_start <= 1'b1;
      @(posedge mclk);
      ramp_start <= 1'b0;
      i_sup.pull_low(2);
      repeat (8) @(posedge mclk);
      acc(7'h0e, 0, 0, 32'h0);
      i_sup.pull_low(3);
      halt_wait();
      chk(event_flag_register, 32'h400);
      @(negedge mclk);
      chk(scale_out, p[31:24]);
      v = v_actual;
      repeat (40) begin
         @(negedge mclk);
         v = v > d ? v - d : 0;
         chk(v_actual, v);
      end
      @(posedge mclk);
      v_target <= 32'h7fff;
      acc(7'h22, 0, 0, 32'h0);
      acc(7'h4e, 0, 0, p);
      acc(7'h0e, 0, 0, 32'h400);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      ramp_start <= 1'b1;
      normal_scale <= 8'h3c;
      @(posedge mclk);
      ramp_start <= 1'b0;
      acc(7'h4e, 1, p, 0);
      acc(7'h4e, 0, 0, 32'h0);
      i_sup.pull_low(4);
      halt_wait();
      chk(v_actual, 32'h0);
      @(posedge mclk);
      normal_scale <= 8'hc3;
      repeat (3) @(negedge mclk);
      chk(scale_out, 8'h3c);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
